// [hw/mtrdr_defs.vh]
/*
 Constants for the meter display and result register bank: register
 addresses on the device's serial register port, reset values, field
 positions and fixed display patterns.
 Assumes the includer uses the macros at their declared widths.
*/
`ifndef MTRDR_DEFS_VH
`define MTRDR_DEFS_VH

// Register addresses (five address bits of the command byte)
`define MTRDR_ADDR_ULIM 5'h05
`define MTRDR_ADDR_SEGLO 5'h06
`define MTRDR_ADDR_SEGMID 5'h07
`define MTRDR_ADDR_SEGHI 5'h08
`define MTRDR_ADDR_TRIM 5'h09
`define MTRDR_ADDR_RES1 5'h0a
`define MTRDR_ADDR_DISP 5'h0b

// Reset values
`define MTRDR_ULIM_RST_45 16'hb1e0
`define MTRDR_ULIM_RST_35 16'h8300
`define MTRDR_SEG16_RST 16'h0000
`define MTRDR_SEG8_RST 8'h00
`define MTRDR_TRIM_RST 16'h0000
`define MTRDR_RES1_RST 16'h0000
`define MTRDR_DISP_RST 16'h0000

// Low and mid segment word bit 0 always reads zero
`define MTRDR_SEG_ZERO_MASK 16'hfffe

// Digit-4 bits in the mid and high segment words
`define MTRDR_MID_DIG4_MASK 16'he000
`define MTRDR_HI_DIG4_MASK 8'h1f
`define MTRDR_HI_LEADONE_BIT 5

// Underrange pattern, stored form (0 lights): minus, leading one, g dashes
`define MTRDR_UNDER_LO 16'hbfde
`define MTRDR_UNDER_MID 16'heefe
`define MTRDR_UNDER_HI_45 8'hdd
`define MTRDR_UNDER_HI_35 8'hdf

// Alignment of the 16-bit trim to the 20-bit conversion value
`define MTRDR_TRIM_SHIFT 4

`endif

// [hw/mtrdr_offset_sub.v]
/*
 Trim subtractor: takes the auto-calibrated conversion value and removes
 the user trim, aligned with the upper sixteen bits of the result.
 Assumes both operands are two's complement and the caller registers it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mtrdr_defs.vh"

module mtrdr_offset_sub (
    // Operands
    input wire [19:0] calValue,
    input wire [15:0] trimValue,
    // Difference
    output wire [19:0] finalValue
);

    wire [19:0] trimAligned;

    // Trim weighted like the upper result word, wraps modulo 2^20
    assign trimAligned = {trimValue, {`MTRDR_TRIM_SHIFT{1'b0}}};
    assign finalValue = calValue - trimAligned;

endmodule // mtrdr_offset_sub
`default_nettype wire

// [hw/mtrdr_result_bank.v]
/*
 Result, limit and display register bank of the panel-meter converter.
 Holds the underrange limit and flag, the three segment words, the user
 trim, the upper result word and the display value, and picks what the
 LCD shows.
 Assumes the serial command decoder, the conversion filter, the peak
 tracker and the control register all run on ref_clk and hand over
 single-cycle strobes; nothing here crosses clock domains.
*/
//
// Summary of operation
// - Underrange limit is 16-bit signed RW, reset by variant to 8300h or B1E0h.
// - A result below the signed limit sets the below-limit flag.
// - Underrange shows minus one then three or four dashes.
// - Segment words drive the glass only while direct select is one.
// - Segment bits are inverted: zero lights, one blanks; reset lights all.
// - Low segment word: 16-bit RW, bits 15..1 digit 2/annunciator/digit 1, bit0 zero.
// - Mid segment word: 16-bit RW, digit 4/minus/digit 3/battery/digit 2, bit0 zero.
// - High segment word: 8-bit RW, peak, hold, leading one, digit 4.
// - Leading-one bit drives fifth pair on 4.5 digits, fourth on 3.5.
// - Digit-4 bits matter only on the 4.5-digit variant.
// - User trim is 16-bit signed RW; result is calibrated input minus trim.
// - Upper result word is 16-bit read-only signed, reset zero.
// - Upper result uses 16 bits on 4.5 digits, bits 15..4 on 3.5; the bank captures all 16 bits on both variants.
// - Display value is 16-bit RW, loaded from result, peak or serial writes.
// - On 3.5 digits the display value keeps 12 bits plus four sub-bits.
// - Source order: segments, user value, hold, peak, then conversion result.
// - Below-limit flag latches; status read clears it unless still underrange.
// - Hold freezes the display value while conversions keep running.
`timescale 1ns/1ps
`default_nettype none
`include "mtrdr_defs.vh"

module mtrdr_result_bank #(
    parameter FOUR_HALF = 1
) (
    // Clock, reset and freeze
    input wire ref_clk,
    input wire rstn,
    input wire clkEn,
    // Register port from the serial command decoder
    input wire [4:0] regAddr,
    input wire regWrEn,
    input wire regRdEn,
    input wire [15:0] regWrData,
    output reg [15:0] regRdData,
    output reg regRdValid,
    // Status register read strobe
    input wire statusRead,
    // Conversion stream from the filter
    input wire convValid,
    input wire [19:0] convCalValue,
    // Peak register value
    input wire [15:0] peakValue,
    // Control bits
    input wire segmentDirectSelect,
    input wire displaySourceUser,
    input wire holdEnable,
    input wire peakEnable,
    // Status towards the status register
    output reg belowLimitFlag,
    output reg [3:0] resultLowNibble,
    // Display driver side
    output reg dispNumeric,
    output reg [15:0] dispValue,
    output reg [37:0] dispSegOn,
    output reg dispFifthPair,
    output reg dispFourthPair
);

    // Source selection codes
    localparam SRC_SEGMENT = 3'd0;
    localparam SRC_USER = 3'd1;
    localparam SRC_HOLD = 3'd2;
    localparam SRC_PEAK = 3'd3;
    localparam SRC_RESULT = 3'd4;

    localparam [15:0] ULIM_RST = FOUR_HALF ? `MTRDR_ULIM_RST_45 : `MTRDR_ULIM_RST_35;
    localparam [7:0] UNDER_HI = FOUR_HALF ? `MTRDR_UNDER_HI_45 : `MTRDR_UNDER_HI_35;

    // Register file
    reg [15:0] underrangeLimit_r;
    reg [15:0] segmentPatternLow_r;
    reg [15:0] segmentPatternMid_r;
    reg [7:0] segmentPatternHigh_r;
    reg [15:0] userOffsetTrim_r;
    reg [15:0] conversionResultUpper_r;
    reg [15:0] displayValue_r;
    reg [15:0] displayValue_nxt;
    // Underrange tracking
    reg underNow_r;
    reg belowLimit_nxt;
    // Display selection
    reg [2:0] dispSrc;
    reg [15:0] rdMux;
    reg [15:0] showLow;
    reg [15:0] showMid;
    reg [7:0] showHigh;

    wire [19:0] convFinal;
    wire [15:0] convUpper;
    wire convBelow;
    wire [37:0] mapSegOn;
    wire mapFifth;
    wire mapFourth;
    wire wrLimit;
    wire wrSegLow;
    wire wrSegMid;
    wire wrSegHigh;
    wire wrTrim;
    wire wrDisp;

    // Signed compare of two 16-bit words, a below b
    function signedBelow;
        input [15:0] a;
        input [15:0] b;
        begin
            signedBelow = $signed(a) < $signed(b);
        end
    endfunction

    // Address match qualified by the write strobe
    function wrHit;
        input [4:0] addr;
        input [4:0] target;
        input strobe;
        begin
            wrHit = strobe && (addr == target);
        end
    endfunction

    // Keep bit 0 of a segment word at zero
    function [15:0] segWord;
        input [15:0] d;
        begin
            segWord = d & `MTRDR_SEG_ZERO_MASK;
        end
    endfunction

    // Trim removal on the incoming conversion
    mtrdr_offset_sub uOffsetSub (
        .calValue(convCalValue),
        .trimValue(userOffsetTrim_r),
        .finalValue(convFinal)
    );

    // Segment mapping of whichever pattern is shown
    mtrdr_seg_map #(
        .FOUR_HALF(FOUR_HALF)
    ) uSegMap (
        .patLow(showLow),
        .patMid(showMid),
        .patHigh(showHigh),
        .segOn(mapSegOn),
        .fifthPositionPair(mapFifth),
        .fourthPositionPair(mapFourth)
    );

    // Upper result word and its compare against the limit
    assign convUpper = convFinal[19:4];
    assign convBelow = signedBelow(convUpper, underrangeLimit_r);

    // Write decode; the result word has no write path
    assign wrLimit = wrHit(regAddr, `MTRDR_ADDR_ULIM, regWrEn);
    assign wrSegLow = wrHit(regAddr, `MTRDR_ADDR_SEGLO, regWrEn);
    assign wrSegMid = wrHit(regAddr, `MTRDR_ADDR_SEGMID, regWrEn);
    assign wrSegHigh = wrHit(regAddr, `MTRDR_ADDR_SEGHI, regWrEn);
    assign wrTrim = wrHit(regAddr, `MTRDR_ADDR_TRIM, regWrEn);
    assign wrDisp = wrHit(regAddr, `MTRDR_ADDR_DISP, regWrEn);

    // Writable configuration registers
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            underrangeLimit_r <= ULIM_RST;
            segmentPatternLow_r <= `MTRDR_SEG16_RST;
            segmentPatternMid_r <= `MTRDR_SEG16_RST;
            segmentPatternHigh_r <= `MTRDR_SEG8_RST;
            userOffsetTrim_r <= `MTRDR_TRIM_RST;
        end else if (clkEn) begin
            if (wrLimit) begin
                underrangeLimit_r <= regWrData;
            end
            if (wrSegLow) begin
                segmentPatternLow_r <= segWord(regWrData);
            end
            if (wrSegMid) begin
                segmentPatternMid_r <= segWord(regWrData);
            end
            if (wrSegHigh) begin
                segmentPatternHigh_r <= regWrData[7:0];
            end
            if (wrTrim) begin
                userOffsetTrim_r <= regWrData;
            end
        end
    end

    // Result capture on each conversion; register writes never reach it
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            conversionResultUpper_r <= `MTRDR_RES1_RST;
            resultLowNibble <= 4'h0;
            underNow_r <= 1'b0;
        end else if (clkEn) begin
            if (convValid) begin
                conversionResultUpper_r <= convUpper;
                resultLowNibble <= convFinal[3:0];
                underNow_r <= convBelow;
            end
        end
    end

    // Display source priority
    always @* begin
        if (segmentDirectSelect) begin
            dispSrc = SRC_SEGMENT;
        end else if (displaySourceUser) begin
            dispSrc = SRC_USER;
        end else if (holdEnable) begin
            dispSrc = SRC_HOLD;
        end else if (peakEnable) begin
            dispSrc = SRC_PEAK;
        end else begin
            dispSrc = SRC_RESULT;
        end
    end

    // Next display value: serial writes always land, feeds by source
    always @* begin
        displayValue_nxt = displayValue_r;
        case (dispSrc)
            SRC_PEAK: begin
                displayValue_nxt = peakValue;
            end
            SRC_RESULT: begin
                if (convValid) begin
                    displayValue_nxt = convUpper;
                end
            end
            SRC_HOLD: begin
                displayValue_nxt = displayValue_r;
            end
            default: begin
                displayValue_nxt = displayValue_r;
            end
        endcase
        if (wrDisp) begin
            displayValue_nxt = regWrData;
        end
    end

    // Display value register, all sixteen bits kept
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            displayValue_r <= `MTRDR_DISP_RST;
        end else if (clkEn) begin
            displayValue_r <= displayValue_nxt;
        end
    end

    // Below-limit flag; a new underrange wins over the clearing read
    always @* begin
        belowLimit_nxt = belowLimitFlag;
        if (statusRead && !underNow_r) begin
            belowLimit_nxt = 1'b0;
        end
        if (convValid && convBelow) begin
            belowLimit_nxt = 1'b1;
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            belowLimitFlag <= 1'b0;
        end else if (clkEn) begin
            belowLimitFlag <= belowLimit_nxt;
        end
    end

    // Pattern fed to the mapper: underrange pattern when not in segment mode and underrange, else segment words
    always @* begin
        showLow = segmentPatternLow_r;
        showMid = segmentPatternMid_r;
        showHigh = segmentPatternHigh_r;
        if (dispSrc != SRC_SEGMENT && underNow_r) begin
            showLow = `MTRDR_UNDER_LO;
            showMid = `MTRDR_UNDER_MID;
            showHigh = UNDER_HI;
        end
    end

    // Display driver outputs, registered
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dispNumeric <= 1'b0;
            dispValue <= 16'h0000;
            dispSegOn <= {38{1'b0}};
            dispFifthPair <= 1'b0;
            dispFourthPair <= 1'b0;
        end else if (clkEn) begin
            dispNumeric <= (dispSrc != SRC_SEGMENT) && !underNow_r;
            dispValue <= displayValue_nxt;
            if (dispSrc == SRC_SEGMENT || underNow_r) begin
                dispSegOn <= mapSegOn;
                dispFifthPair <= mapFifth;
                dispFourthPair <= mapFourth;
            end else begin
                dispSegOn <= {38{1'b0}};
                dispFifthPair <= 1'b0;
                dispFourthPair <= 1'b0;
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        case (regAddr)
            `MTRDR_ADDR_ULIM: begin
                rdMux = underrangeLimit_r;
            end
            `MTRDR_ADDR_SEGLO: begin
                rdMux = segmentPatternLow_r;
            end
            `MTRDR_ADDR_SEGMID: begin
                rdMux = segmentPatternMid_r;
            end
            `MTRDR_ADDR_SEGHI: begin
                rdMux = {8'h00, segmentPatternHigh_r};
            end
            `MTRDR_ADDR_TRIM: begin
                rdMux = userOffsetTrim_r;
            end
            `MTRDR_ADDR_RES1: begin
                rdMux = conversionResultUpper_r;
            end
            `MTRDR_ADDR_DISP: begin
                rdMux = displayValue_r;
            end
            default: begin
                rdMux = 16'h0000;
            end
        endcase
    end

    // Read data held until the next read
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else if (clkEn) begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= rdMux;
            end
        end
    end

endmodule // mtrdr_result_bank
`default_nettype wire

// [hw/mtrdr_seg_map.v]
/*
 Segment mapper: turns the three stored segment words into one vector of
 active-high segment enables for the LCD waveform generator.
 Assumes the words arrive in stored form, where a zero lights a segment.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mtrdr_defs.vh"

module mtrdr_seg_map #(
    parameter FOUR_HALF = 1
) (
    // Stored segment words
    input wire [15:0] patLow,
    input wire [15:0] patMid,
    input wire [7:0] patHigh,
    // Active-high segment enables
    output wire [37:0] segOn,
    output wire fifthPositionPair,
    output wire fourthPositionPair
);

    wire [15:0] midMask;
    wire [7:0] hiMask;
    wire leadingOneSegPair;

    // Digit-4 segments only exist on the 4.5-digit glass
    assign midMask = FOUR_HALF ? 16'hffff : ~`MTRDR_MID_DIG4_MASK;
    assign hiMask = FOUR_HALF ? 8'hff : ~`MTRDR_HI_DIG4_MASK;

    // Inverted polarity: a stored zero lights the segment
    assign segOn = {~patHigh & hiMask, ~patMid[15:1] & midMask[15:1], ~patLow[15:1]};

    // Leading-one pair lands on the fifth or fourth position by variant
    assign leadingOneSegPair = ~patHigh[`MTRDR_HI_LEADONE_BIT];
    assign fifthPositionPair = FOUR_HALF ? leadingOneSegPair : 1'b0;
    assign fourthPositionPair = FOUR_HALF ? 1'b0 : leadingOneSegPair;

endmodule // mtrdr_seg_map
`default_nettype wire

// [tb/mtrdr_host_model.sv]
/* Host controller model: issues register reads and writes to the bank.
   Assumes one ref_clk; requests change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none

module mtrdr_host_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [4:0] regAddr,
    output logic regWrEn,
    output logic regRdEn,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid
);
    // Idle port at time zero
    initial begin
        regAddr = 5'h1f;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 16'h0000;
    end

    // One write strobe; released lines show the inverse, not stale data
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge ref_clk);
        regWrEn = 1'b0;
        regWrData = ~d;
        regAddr = ~a;
    endtask

    // One read strobe; returns valid and data of the answer cycle
    task automatic rd(input logic [4:0] a, output logic [16:0] q);
        @(negedge ref_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge ref_clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        q = {regRdValid, regRdData};
    endtask
endmodule // mtrdr_host_model
`default_nettype wire

// [tb/mtrdr_result_bank_bench.sv]
/* Self-checking bench for the result bank, both digit variants.
   Assumes the host model on the register port and a 20 MHz ref_clk. */
`timescale 1ns/1ps
`default_nettype none
`include "mtrdr_defs.vh"

module mtrdr_result_bank_bench;
    // Stimulus
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic clkEn = 1'b1;
    logic statusRead = 1'b0;
    logic convValid = 1'b0;
    logic [19:0] convCalValue = 20'h00000;
    logic [15:0] peakValue = 16'h0000;
    logic segmentDirectSelect = 1'b0;
    logic displaySourceUser = 1'b0;
    logic holdEnable = 1'b0;
    logic peakEnable = 1'b0;
    // Register port and outputs
    wire logic [4:0] regAddr;
    wire logic regWrEn;
    wire logic regRdEn;
    wire logic [15:0] regWrData;
    wire logic [15:0] regRdData;
    wire logic regRdValid;
    wire logic belowLimitFlag;
    wire logic [3:0] resultLowNibble;
    wire logic dispNumeric;
    wire logic [15:0] dispValue;
    wire logic [37:0] dispSegOn;
    wire logic dispFifthPair;
    wire logic dispFourthPair;
    wire logic [15:0] regRdData35;
    wire logic regRdValid35;
    wire logic [37:0] dispSegOn35;
    wire logic dispFifthPair35;
    wire logic dispFourthPair35;
    int failCount = 0;
    int samplesChecked = 0;
    logic [4:0] regList [8] = '{`MTRDR_ADDR_ULIM, `MTRDR_ADDR_SEGLO, `MTRDR_ADDR_SEGMID,
        `MTRDR_ADDR_SEGHI, `MTRDR_ADDR_TRIM, `MTRDR_ADDR_RES1, `MTRDR_ADDR_DISP, 5'h1f};

    // 50 ns clock
    always #25 ref_clk = ~ref_clk;

    // 3.5-digit variant on the same stimulus
    mtrdr_result_bank #(.FOUR_HALF(0)) uut35 (
        .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData35), .regRdValid(regRdValid35),
        .statusRead(statusRead), .convValid(convValid), .convCalValue(convCalValue),
        .peakValue(peakValue), .segmentDirectSelect(segmentDirectSelect),
        .displaySourceUser(displaySourceUser), .holdEnable(holdEnable), .peakEnable(peakEnable),
        .belowLimitFlag(), .resultLowNibble(), .dispNumeric(), .dispValue(), .dispSegOn(dispSegOn35),
        .dispFifthPair(dispFifthPair35), .dispFourthPair(dispFourthPair35)
    );

    mtrdr_result_bank #(.FOUR_HALF(1)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .statusRead(statusRead), .convValid(convValid), .convCalValue(convCalValue),
        .peakValue(peakValue), .segmentDirectSelect(segmentDirectSelect),
        .displaySourceUser(displaySourceUser), .holdEnable(holdEnable), .peakEnable(peakEnable),
        .belowLimitFlag(belowLimitFlag), .resultLowNibble(resultLowNibble), .dispNumeric(dispNumeric),
        .dispValue(dispValue), .dispSegOn(dispSegOn), .dispFifthPair(dispFifthPair),
        .dispFourthPair(dispFourthPair)
    );

    mtrdr_host_model host (
        .ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid)
    );

    // Compare and count
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One conversion pulse
    task automatic conv(input logic [19:0] v);
        @(negedge ref_clk);
        convCalValue = v;
        convValid = 1'b1;
        @(negedge ref_clk);
        convValid = 1'b0;
        convCalValue = ~v;
    endtask

    // One status-read pulse
    task automatic stRead;
        @(negedge ref_clk);
        statusRead = 1'b1;
        @(negedge ref_clk);
        statusRead = 1'b0;
    endtask

    // Reset values, unmapped address reads zero
    task automatic tReset;
        logic [16:0] q;
        for (int i = 0; i < 8; i++) begin
            host.rd(regList[i], q);
            chk(40'(q), 40'({1'b1, (i == 0) ? 16'hb1e0 : 16'h0000}));
            if (i == 0) chk(40'({regRdValid35, regRdData35}), 40'h18300);
        end
    endtask

    // All-ones write everywhere, then read back masks and the read-only word
    task automatic tRw;
        logic [16:0] q;
        logic [15:0] e [8] = '{16'hffff, 16'hfffe, 16'hfffe, 16'h00ff, 16'hffff, 16'h0000, 16'hffff, 16'h0000};
        for (int i = 0; i < 8; i++) host.wr(regList[i], 16'hffff);
        for (int i = 0; i < 8; i++) begin
            host.rd(regList[i], q);
            chk(40'(q), 40'({1'b1, e[i]}));
        end
    endtask

    // Trim subtraction and result word
    task automatic tConv;
        logic [16:0] q;
        host.wr(`MTRDR_ADDR_TRIM, 16'h0010);
        conv(20'h12345);
        chk(40'(resultLowNibble), 40'h5);
        @(negedge ref_clk);
        chk(40'({dispNumeric, dispValue}), 40'h11224);
        host.rd(`MTRDR_ADDR_RES1, q);
        chk(40'(q), 40'h11224);
    endtask

    // One below the limit, then exactly at it
    task automatic tUnder;
        host.wr(`MTRDR_ADDR_ULIM, 16'hb1e0);
        host.wr(`MTRDR_ADDR_TRIM, 16'h0000);
        conv(20'hb1df0);
        chk(40'(belowLimitFlag), 40'h1);
        @(negedge ref_clk);
        chk(40'({dispFifthPair, dispNumeric, dispSegOn}), 40'h8884402010);
        chk(40'({dispFifthPair35, dispFourthPair35, dispSegOn35}), 40'h4804402010);
        stRead();
        chk(40'(belowLimitFlag), 40'h1);
        conv(20'hb1e00);
        @(negedge ref_clk);
        chk(40'({belowLimitFlag, dispNumeric, dispValue}), 40'h3b1e0);
        stRead();
        chk(40'(belowLimitFlag), 40'h0);
    endtask

    // Direct segment drive, a pattern and the all-lit reset pattern
    task automatic tSeg;
        logic [15:0] lo [2] = '{16'ha5a4, 16'h0000};
        logic [15:0] mid [2] = '{16'h3c3c, 16'h0000};
        logic [7:0] hi [2] = '{8'h96, 8'h00};
        for (int i = 0; i < 2; i++) begin
            host.wr(`MTRDR_ADDR_SEGLO, lo[i]);
            host.wr(`MTRDR_ADDR_SEGMID, mid[i]);
            host.wr(`MTRDR_ADDR_SEGHI, 16'(hi[i]));
            segmentDirectSelect = 1'b1;
            repeat (2) @(negedge ref_clk);
            chk(40'({dispFifthPair, dispNumeric, dispSegOn}),
                40'({~hi[i][5], 1'b0, ~hi[i], ~mid[i][15:1], ~lo[i][15:1]}));
            chk(40'({dispFourthPair, dispFifthPair35}), 40'h0);
            chk(40'({dispFourthPair35, dispSegOn35}),
                40'({~hi[i][5], ~hi[i] & 8'he0, ~mid[i][15:1] & 15'h0fff, ~lo[i][15:1]}));
            segmentDirectSelect = 1'b0;
        end
    endtask

    // Each display source alone in turn: user, hold, peak, result
    task automatic tSource;
        logic [16:0] q;
        host.wr(`MTRDR_ADDR_DISP, 16'h0abc);
        displaySourceUser = 1'b1;
        conv(20'h01000);
        @(negedge ref_clk);
        chk(40'(dispValue), 40'h0abc);
        displaySourceUser = 1'b0;
        holdEnable = 1'b1;
        conv(20'h02000);
        @(negedge ref_clk);
        chk(40'(dispValue), 40'h0abc);
        host.rd(`MTRDR_ADDR_RES1, q);
        chk(40'(q), 40'h10200);
        holdEnable = 1'b0;
        peakEnable = 1'b1;
        peakValue = 16'h0777;
        repeat (2) @(negedge ref_clk);
        chk(40'(dispValue), 40'h0777);
        peakEnable = 1'b0;
        conv(20'h03000);
        @(negedge ref_clk);
        chk(40'(dispValue), 40'h0300);
    endtask

    // Verdict and end of run
    task automatic giveVerdict;
        if (failCount == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the expected 116 or so cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        failCount++;
        giveVerdict();
    end

    // Main sequence
    initial begin
        repeat (16) @(negedge ref_clk);
        rstn = 1'b1;
        tReset();
        tRw();
        tConv();
        tUnder();
        tSeg();
        tSource();
        giveVerdict();
    end
endmodule // mtrdr_result_bank_bench
`default_nettype wire

// [tb/mtrdr_result_bank_properties.sv]
/* Checker for the result bank ports, bound into every instance.
   Assumes ref_clk is the only clock and rstn an async low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "mtrdr_defs.vh"

module mtrdr_result_bank_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Register port
    input wire logic [4:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid,
    // Conversion, status and control
    input wire logic statusRead,
    input wire logic convValid,
    input wire logic [19:0] convCalValue,
    input wire logic [15:0] peakValue,
    input wire logic segmentDirectSelect,
    input wire logic displaySourceUser,
    input wire logic holdEnable,
    input wire logic peakEnable,
    // Watched outputs
    input wire logic belowLimitFlag,
    input wire logic [3:0] resultLowNibble,
    input wire logic dispNumeric,
    input wire logic [15:0] dispValue
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Trim sits above bit 3, so the low nibble passes straight through
    wire logic [3:0] calNibble = convCalValue[3:0];

    AST_READ_VALID: assert property (clkEn |=> regRdValid == $past(regRdEn))
        else $error("read valid does not follow the read strobe");
    AST_SEG_BIT0: assert property (clkEn && regRdEn && (regAddr == `MTRDR_ADDR_SEGLO ||
        regAddr == `MTRDR_ADDR_SEGMID) |=> regRdData[0] == 1'b0)
        else $error("segment word bit 0 read as one");
    AST_SEGHI_BYTE: assert property (clkEn && regRdEn && regAddr == `MTRDR_ADDR_SEGHI
        |=> regRdData[15:8] == 8'h00)
        else $error("high segment word upper byte not zero");
    AST_FLAG_RISE: assert property ($rose(belowLimitFlag) |-> $past(clkEn && convValid))
        else $error("below-limit flag set without a conversion");
    AST_FLAG_FALL: assert property ($fell(belowLimitFlag) |-> $past(clkEn && statusRead))
        else $error("below-limit flag cleared without a status read");
    AST_SEG_SELECT: assert property (clkEn && segmentDirectSelect |=> !dispNumeric)
        else $error("numeric display while segment select is set");
    AST_PEAK_SOURCE: assert property (clkEn && peakEnable && !(holdEnable || displaySourceUser ||
        segmentDirectSelect || regWrEn) |=> dispValue == $past(peakValue))
        else $error("display value does not follow the peak value");
    AST_HOLD_FREEZE: assert property (clkEn && holdEnable && !(displaySourceUser ||
        segmentDirectSelect || regWrEn) |=> $stable(dispValue))
        else $error("display value changed while held");
    AST_USER_FREEZE: assert property (clkEn && displaySourceUser && !segmentDirectSelect
        && !regWrEn |=> $stable(dispValue))
        else $error("user display value changed without a write");
    AST_LOW_NIBBLE: assert property (clkEn && convValid |=> resultLowNibble == $past(calNibble))
        else $error("result low nibble not taken from the conversion");
endmodule // mtrdr_result_bank_properties

bind mtrdr_result_bank mtrdr_result_bank_properties chk (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid), .statusRead(statusRead),
    .convValid(convValid), .convCalValue(convCalValue), .peakValue(peakValue),
    .segmentDirectSelect(segmentDirectSelect), .displaySourceUser(displaySourceUser),
    .holdEnable(holdEnable), .peakEnable(peakEnable), .belowLimitFlag(belowLimitFlag),
    .resultLowNibble(resultLowNibble), .dispNumeric(dispNumeric), .dispValue(dispValue)
);
`default_nettype wire
